/* hw/nand_host.v */
// What the document requires
// [R01] Command cycles: command latch high, strobe rises
// [R02] Address cycles: address latch high only then
// [R03] Device latches bytes on write strobe rise
// [R04] Select exactly one die, low while cycling
// [R05] Read strobe fall advances device column
// [R06] Read strobe cycle at least 25 ns
// [R07] Device floats bus when deselected
// [R08] Device busy low during program, erase, read
// [R09] Ready/busy open drain, valid when deselected
// [R10] Write protect low blocks program and erase
// [R11] Page and block sizes are fixed
// [R12] Program about 230 us, erase 700 us
// [R13] Device sequences program and erase itself
// [R14] Two dies share bus and latches
// [R15] Copy-back protected by on-chip error detection
// [R16] Wait ready per die, other die free (a wait here holds off requests for both dies)
`timescale 1ns/1ps
`include "nand_host_consts.vh"
module nand_host #(
    parameter FIFO_DEPTH = 32,
    parameter FIFO_AW    = 5,
    parameter BUSY_WAIT  = `BUSY_WAIT_CYC
) (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_n_i,
    // Request stream: {die, kind[1:0], byte}
    input  wire        req_valid_i,
    output wire        req_ready_o,
    input  wire [10:0] req_data_i,
    // Read data answer
    output reg         rd_valid_o,
    output reg  [7:0]  rd_data_o,
    // Ready wait request and status
    input  wire        wait_start_i,
    input  wire        wait_die_i,
    output wire        wait_busy_o,
    output reg         wait_timeout_o,
    output wire [1:0]  die_ready_o,
    // Write protect control
    input  wire        wp_allow_i,
    // Flash pins
    input  wire [7:0]  io_in_i,
    output reg  [7:0]  io_out_o,
    output reg         io_oe_o,
    output reg         cmd_latch_o,
    output reg         addr_latch_o,
    output reg  [1:0]  die_select_n_o,
    output reg  [1:0]  wr_strobe_n_o,
    output reg  [1:0]  rd_strobe_n_o,
    output reg         wr_protect_n_o,
    input  wire [1:0]  op_pending_n_i
);
    localparam S_IDLE = 2'h0;
    localparam S_LOW  = 2'h1;
    localparam S_HIGH = 2'h2;
    localparam S_WAIT = 2'h3;
    localparam integer PHASE_CYC = `STROBE_PHASE_CYC;
    localparam [7:0]   PHASE     = PHASE_CYC[7:0];

    reg  [1:0]  state_q;
    reg  [7:0]  phase_q;
    reg  [10:0] cur_q;
    reg  [31:0] wait_cnt_q;
    reg         wait_die_q;
    reg  [1:0]  rb_s1_q;
    reg  [1:0]  rb_s2_q;
    reg  [1:0]  rb_s3_q;
    reg  [1:0]  rb_q;
    wire [1:0]  rb_d;
    reg  [7:0]  io_s1_q;
    reg  [7:0]  io_s2_q;
    wire        f_valid;
    wire        f_ready;
    wire [10:0] f_data;
    wire [1:0]  cur_kind;
    wire        cur_die;
    wire        cur_rd;

    cycle_fifo #(
        .WIDTH (`REQ_WIDTH),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (req_valid_i),
        .in_ready_o  (req_ready_o),
        .in_data_i   (req_data_i),
        .out_valid_o (f_valid),
        .out_ready_i (f_ready),
        .out_data_o  (f_data)
    );

    assign cur_kind    = cur_q[`REQ_KIND_HI:`REQ_KIND_LO];
    assign cur_die     = cur_q[`REQ_DIE_BIT];
    assign cur_rd      = (cur_kind == `KIND_RDATA);
    // A wait start wins the idle cycle, so the queue head must not pop then
    assign f_ready     = (state_q == S_IDLE) && !wait_start_i;
    assign wait_busy_o = (state_q == S_WAIT);
    assign die_ready_o = rb_q;

    // Per die: a change counts once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_rb
            assign rb_d[g] = (rb_s2_q[g] == rb_s3_q[g]) ? rb_s3_q[g] : rb_q[g]; // R09
        end
    endgenerate

    // Ready/busy filter: three stages, change accepted when 2nd and 3rd agree
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rb_s1_q <= 2'h3;
            rb_s2_q <= 2'h3;
            rb_s3_q <= 2'h3;
            rb_q    <= 2'h3;
            io_s1_q <= 8'h00;
            io_s2_q <= 8'h00;
        end else begin
            rb_s1_q <= op_pending_n_i;
            rb_s2_q <= rb_s1_q;
            rb_s3_q <= rb_s2_q;
            rb_q    <= rb_d;
            io_s1_q <= io_in_i;
            io_s2_q <= io_s1_q;
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q        <= S_IDLE;
            phase_q        <= 8'h00;
            cur_q          <= 11'h000;
            wait_cnt_q     <= 32'h0;
            wait_die_q     <= 1'b0;
            wait_timeout_o <= 1'b0;
            rd_valid_o     <= 1'b0;
            rd_data_o      <= 8'h00;
            io_out_o       <= 8'h00;
            io_oe_o        <= 1'b0;
            cmd_latch_o    <= 1'b0;
            addr_latch_o   <= 1'b0;
            die_select_n_o <= 2'h3;
            wr_strobe_n_o  <= 2'h3;
            rd_strobe_n_o  <= 2'h3;
            wr_protect_n_o <= 1'b0;
        end else begin
            wr_protect_n_o <= wp_allow_i; // R10
            rd_valid_o     <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    wr_strobe_n_o <= 2'h3;
                    rd_strobe_n_o <= 2'h3;
                    if (wait_start_i) begin
                        wait_die_q     <= wait_die_i;
                        wait_cnt_q     <= 32'h0;
                        wait_timeout_o <= 1'b0;
                        state_q        <= S_WAIT;
                    end else if (f_valid) begin
                        cur_q          <= f_data;
                        // One die selected at a time
                        die_select_n_o <= f_data[`REQ_DIE_BIT] ? 2'h1 : 2'h2; // R04 R14
                        cmd_latch_o    <= (f_data[`REQ_KIND_HI:`REQ_KIND_LO] == `KIND_CMD); // R01
                        addr_latch_o   <= (f_data[`REQ_KIND_HI:`REQ_KIND_LO] == `KIND_ADDR); // R02
                        io_out_o       <= f_data[7:0];
                        io_oe_o        <= (f_data[`REQ_KIND_HI:`REQ_KIND_LO] != `KIND_RDATA);
                        phase_q        <= 8'h00;
                        state_q        <= S_LOW;
                    end
                end
                S_LOW: begin
                    if (cur_rd) begin
                        rd_strobe_n_o[cur_die] <= 1'b0; // R05
                    end else begin
                        wr_strobe_n_o[cur_die] <= 1'b0;
                    end
                    if (phase_q + 8'h01 >= PHASE + 8'h01) begin
                        phase_q <= 8'h00;
                        state_q <= S_HIGH;
                    end else begin
                        phase_q <= phase_q + 8'h01;
                    end
                end
                S_HIGH: begin
                    // Rising edge latches the byte; data held across it
                    wr_strobe_n_o <= 2'h3; // R03
                    rd_strobe_n_o <= 2'h3;
                    // Last high cycle: two stages back is the bus while strobe was low
                    if (phase_q == PHASE && cur_rd) begin
                        rd_data_o  <= io_s2_q;
                        rd_valid_o <= 1'b1;
                    end
                    // Full low plus high phase keeps the read cycle long enough
                    if (phase_q + 8'h01 >= PHASE + 8'h01) begin // R06
                        cmd_latch_o  <= 1'b0;
                        addr_latch_o <= 1'b0;
                        io_oe_o      <= 1'b0;
                        state_q      <= S_IDLE;
                    end else begin
                        phase_q <= phase_q + 8'h01;
                    end
                end
                S_WAIT: begin
                    // Hold off queued requests for both dies until the waited die reports ready or the wait count reaches BUSY_WAIT
                    if (rb_q[wait_die_q]) begin // R16 R08
                        state_q <= S_IDLE;
                    end else if (wait_cnt_q >= BUSY_WAIT) begin // R12
                        wait_timeout_o <= 1'b1;
                        state_q        <= S_IDLE;
                    end else begin
                        wait_cnt_q <= wait_cnt_q + 32'h1;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule

/* hw/nand_host_consts.vh */
`ifndef NAND_HOST_CONSTS_VH
`define NAND_HOST_CONSTS_VH

// Clock period in ns
`define CLK_PERIOD_NS      100
// Shortest read strobe cycle in ns, and cycles derived (round up, at least 2 phases)
`define RD_CYCLE_MIN_NS    25
// Strobe phase length in clocks: each low and high phase takes this many cycles plus one
`define STROBE_PHASE_CYC   ((`RD_CYCLE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Nominal busy times
`define PROG_TYP_US        230
`define ERASE_TYP_US       700
// Command kinds
`define KIND_CMD           2'h0
`define KIND_ADDR          2'h1
`define KIND_WDATA         2'h2
`define KIND_RDATA         2'h3
// Request word layout
`define REQ_KIND_HI        9
`define REQ_KIND_LO        8
`define REQ_DIE_BIT        10
`define REQ_WIDTH          11
// Busy wait bound in clocks
`define BUSY_WAIT_CYC      ((`ERASE_TYP_US * 1000 * 4) / `CLK_PERIOD_NS)

`endif

/* hw/cycle_fifo.v */
`timescale 1ns/1ps
module cycle_fifo #(
    parameter WIDTH = 11,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    // Clock and reset
    input  wire             clk_i,
    input  wire             rst_n_i,
    // Write side
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    // Read side
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output reg  [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr_q;
    reg [AW:0]      rd_ptr_q;
    reg             out_valid_q;
    wire [AW:0]     count;
    wire            empty;
    wire            do_wr;
    wire            do_rd;

    assign count       = wr_ptr_q - rd_ptr_q;
    assign empty       = (count == {(AW+1){1'b0}});
    assign in_ready_o  = (count != DEPTH[AW:0]) || (DEPTH[AW] == 1'b0 && count[AW]);
    assign do_wr       = in_valid_i && in_ready_o;
    assign do_rd       = !empty && (!out_valid_q || out_ready_i);
    assign out_valid_o = out_valid_q;

    always @(posedge clk_i) begin
        if (do_wr) begin
            mem[wr_ptr_q[AW-1:0]] <= in_data_i;
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_q    <= {(AW+1){1'b0}};
            rd_ptr_q    <= {(AW+1){1'b0}};
            out_valid_q <= 1'b0;
            out_data_o  <= {WIDTH{1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr_q <= wr_ptr_q + {{AW{1'b0}}, 1'b1};
            end
            if (do_rd) begin
                rd_ptr_q    <= rd_ptr_q + {{AW{1'b0}}, 1'b1};
                out_data_o  <= mem[rd_ptr_q[AW-1:0]];
                out_valid_q <= 1'b1;
            end else if (out_ready_i) begin
                out_valid_q <= 1'b0;
            end
        end
    end
endmodule

/* test/nand_host_chk.sv */
`timescale 1ns/1ps
module nand_host_chk (
    input logic       clk_i,
    input logic       rst_n_i,
    input logic       wp_allow_i,
    input logic       rd_valid_o,
    input logic       io_oe_o,
    input logic       cmd_latch_o,
    input logic       addr_latch_o,
    input logic [1:0] die_select_n_o,
    input logic [1:0] wr_strobe_n_o,
    input logic [1:0] rd_strobe_n_o,
    input logic       wr_protect_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence wr_low_s;
        !wr_strobe_n_o[0] [*2];
    endsequence
    sequence wr_high_s;
        wr_strobe_n_o[0] [*2];
    endsequence
    one_die_a: assert property (die_select_n_o != 2'h0)
        else $error("both dies selected");
    latch_excl_a: assert property (!(cmd_latch_o && addr_latch_o))
        else $error("both latches high");
    wr_sel_a: assert property ((~wr_strobe_n_o & die_select_n_o) == 2'h0)
        else $error("write strobe on idle die");
    rd_sel_a: assert property ((~rd_strobe_n_o & die_select_n_o) == 2'h0)
        else $error("read strobe on idle die");
    rd_float_a: assert property (rd_strobe_n_o != 2'h3 |-> !io_oe_o)
        else $error("host drives during read");
    wr_drive_a: assert property (wr_strobe_n_o != 2'h3 |-> io_oe_o)
        else $error("bus undriven during write");
    wr_pulse_a: assert property ($fell(wr_strobe_n_o[0]) |-> wr_low_s ##1 wr_high_s)
        else $error("write strobe phase length");
    wr_hold_a: assert property ($rose(wr_strobe_n_o[0]) |-> $stable({cmd_latch_o, addr_latch_o}))
        else $error("latch moved at strobe rise");
    rd_answer_a: assert property ($fell(rd_strobe_n_o[1]) |-> ##[2:6] rd_valid_o)
        else $error("read answer missing");
    wp_follow_a: assert property ($past(rst_n_i) && $past(wp_allow_i) |-> wr_protect_n_o)
        else $error("protect not released");
    wp_block_a: assert property ($fell(wp_allow_i) |=> !wr_protect_n_o)
        else $error("protect not applied");
endmodule

bind nand_host nand_host_chk i_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .wp_allow_i(wp_allow_i),
    .rd_valid_o(rd_valid_o), .io_oe_o(io_oe_o), .cmd_latch_o(cmd_latch_o),
    .addr_latch_o(addr_latch_o), .die_select_n_o(die_select_n_o), .wr_strobe_n_o(wr_strobe_n_o),
    .rd_strobe_n_o(rd_strobe_n_o), .wr_protect_n_o(wr_protect_n_o));

/* test/nand_dev_model.sv */
`timescale 1ns/1ps
module nand_dev_model #(
    parameter int BUSY_MUL   = 2,
    parameter int PAGE_BYTES = 4320
) (
    input  logic       clk_i,
    input  logic [7:0] io_bus_i,
    input  logic       cmd_latch_i,
    input  logic       addr_latch_i,
    input  logic [1:0] die_select_n_i,
    input  logic [1:0] wr_strobe_n_i,
    input  logic [1:0] rd_strobe_n_i,
    input  logic       wr_protect_n_i,
    output logic [7:0] io_dev_o,
    output logic [1:0] op_pending_n_o
);
    logic [7:0] col[2], last_cmd[2], wcnt[2], drv;
    int         busy[2];
    int         fill[2];
    logic [1:0] page_over;
    initial begin
        col = '{8'h00, 8'h00}; last_cmd = '{8'h00, 8'h00}; wcnt = '{8'h00, 8'h00};
        busy = '{0, 0}; fill = '{0, 0}; page_over = 2'h0; drv = 8'h00;
    end
    task automatic take(input int d);
        if (die_select_n_i[d] === 1'b0) begin
            if (cmd_latch_i) begin
                last_cmd[d] = io_bus_i;
                if (wr_protect_n_i) busy[d] = io_bus_i * BUSY_MUL;
            end else if (addr_latch_i) begin
                col[d] = io_bus_i;
                fill[d] = 0;
            end else begin
                wcnt[d]++;
                fill[d]++;
                if (fill[d] > PAGE_BYTES) page_over[d] = 1'b1;
            end
        end
    endtask
    always @(posedge wr_strobe_n_i[0]) take(0);
    always @(posedge wr_strobe_n_i[1]) take(1);
    always @(negedge rd_strobe_n_i[0]) if (!die_select_n_i[0]) begin drv = col[0]; col[0]++; end
    always @(negedge rd_strobe_n_i[1]) if (!die_select_n_i[1]) begin drv = col[1]; col[1]++; end
    always @(posedge clk_i) for (int d = 0; d < 2; d++) if (busy[d] > 0) busy[d]--;
    // Released bus shows the inverse of the last byte
    assign io_dev_o = ((~rd_strobe_n_i & ~die_select_n_i) != 2'h0) ? drv : ~drv;
    assign op_pending_n_o = {busy[1] == 0, busy[0] == 0};
endmodule

/* test/nand_host_tb_top.sv */
`timescale 1ns/1ps
module nand_host_tb_top;
    logic        clk_i, rst_n_i, req_valid_i, wait_start_i, wait_die_i, wp_allow_i, refused;
    logic [10:0] req_data_i;
    logic [7:0]  rq[$];
    wire         req_ready_o, rd_valid_o, wait_busy_o, wait_timeout_o, io_oe_o;
    wire         cmd_latch_o, addr_latch_o, wr_protect_n_o;
    wire  [7:0]  rd_data_o, io_out_o, dev_io, io_in_i;
    wire  [1:0]  die_ready_o, die_select_n_o, wr_strobe_n_o, rd_strobe_n_o, op_pending_n_i;
    int          err_total, num_checks;
    assign io_in_i = io_oe_o ? io_out_o : dev_io;
    nand_host #(.BUSY_WAIT(50)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_data_i(req_data_i),
        .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .wait_start_i(wait_start_i),
        .wait_die_i(wait_die_i), .wait_busy_o(wait_busy_o), .wait_timeout_o(wait_timeout_o),
        .die_ready_o(die_ready_o), .wp_allow_i(wp_allow_i), .io_in_i(io_in_i),
        .io_out_o(io_out_o), .io_oe_o(io_oe_o), .cmd_latch_o(cmd_latch_o),
        .addr_latch_o(addr_latch_o), .die_select_n_o(die_select_n_o),
        .wr_strobe_n_o(wr_strobe_n_o), .rd_strobe_n_o(rd_strobe_n_o),
        .wr_protect_n_o(wr_protect_n_o), .op_pending_n_i(op_pending_n_i));
    nand_dev_model i_dev (.clk_i(clk_i), .io_bus_i(io_in_i), .cmd_latch_i(cmd_latch_o),
        .addr_latch_i(addr_latch_o), .die_select_n_i(die_select_n_o),
        .wr_strobe_n_i(wr_strobe_n_o), .rd_strobe_n_i(rd_strobe_n_o),
        .wr_protect_n_i(wr_protect_n_o), .io_dev_o(dev_io), .op_pending_n_o(op_pending_n_i));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) if (rd_valid_o === 1'b1) rq.push_back(rd_data_o);
    task give_verdict;
        if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic ok);
        num_checks++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("MISMATCH %0t check %0d wrong", $time, num_checks);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task push(input logic d, input logic [1:0] k, input logic [7:0] b);
        int n; logic r;
        n = 0;
        req_data_i <= {d, k, b};
        req_valid_i <= 1'b1;
        do begin
            @(negedge clk_i); r = req_ready_o;
            if (r !== 1'b1) refused = 1'b1;
            @(posedge clk_i); n++;
        end while (r !== 1'b1 && n < 300);
        if (n >= 300) begin err_total++; give_verdict; end
    endtask
    task op(input logic d, input logic [1:0] k, input logic [7:0] b);
        push(d, k, b);
        req_valid_i <= 1'b0;
        cyc(10);
    endtask
    task wait_rdy(input logic d, output logic to);
        int n;
        n = 0;
        wait_start_i <= 1'b1; wait_die_i <= d;
        cyc(1);
        wait_start_i <= 1'b0;
        do begin @(negedge clk_i); n++; end while (wait_busy_o !== 1'b0 && n < 400);
        if (n >= 400) begin err_total++; give_verdict; end
        to = wait_timeout_o;
        @(posedge clk_i);
    endtask
    task t_cmd_addr;
        op(1'b0, 2'h0, 8'h0C); op(1'b1, 2'h1, 8'hC3);
        chk(i_dev.last_cmd[0] === 8'h0C);
        chk(i_dev.col[1] === 8'hC3);
        chk(i_dev.last_cmd[1] === 8'h00);
    endtask
    task t_read;
        rq.delete();
        op(1'b1, 2'h1, 8'hFE);
        repeat (3) op(1'b1, 2'h3, 8'h00);
        chk(rq.size() == 3 && rq[0] === 8'hFE && rq[1] === 8'hFF && rq[2] === 8'h00);
        chk(i_dev.col[1] === 8'h01);
    endtask
    task t_busy;
        logic to;
        op(1'b0, 2'h0, 8'h0A);
        chk(die_ready_o[0] === 1'b0);
        op(1'b1, 2'h0, 8'h01);
        chk(i_dev.last_cmd[1] === 8'h01);
        wait_rdy(1'b0, to);
        chk(to === 1'b0 && die_ready_o[0] === 1'b1);
        op(1'b1, 2'h0, 8'h40);
        wait_rdy(1'b1, to);
        chk(to === 1'b1);
    endtask
    task t_protect;
        wp_allow_i <= 1'b0; cyc(2);
        chk(wr_protect_n_o === 1'b0);
        op(1'b0, 2'h0, 8'h30);
        chk(die_ready_o[0] === 1'b1);
        wp_allow_i <= 1'b1; cyc(2);
    endtask
    task t_fifo;
        refused = 1'b0;
        for (int i = 0; i < 48; i++) push(1'b0, 2'h2, i[7:0]);
        req_valid_i <= 1'b0;
        cyc(320);
        chk(refused === 1'b1 && i_dev.wcnt[0] === 8'h30);
        chk(i_dev.page_over === 2'h0);
    endtask
    initial begin
        err_total = 0; num_checks = 0; refused = 1'b0;
        rst_n_i = 1'b0; req_valid_i = 1'b0; req_data_i = 11'h000;
        wait_start_i = 1'b0; wait_die_i = 1'b0; wp_allow_i = 1'b1;
        cyc(20);
        rst_n_i <= 1'b1;
        cyc(2);
        t_cmd_addr; t_read; t_busy; t_protect; t_fifo;
        give_verdict;
    end
endmodule
